// ===== rtl/i2csr_slave.sv
`timescale 1ns/1ps
`default_nettype none
module i2csr_slave (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [2:0] addr_sel_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_we_o,
    input wire logic [7:0] reg_rdata_i,
    output logic [7:0] pointer_o,
    output logic busy_o
);
    // Synchronised bus lines
    logic scl_s;
    logic sda_s;
    // Previous synchronised values for edge finding
    logic scl_d_reg;
    logic sda_d_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    // State of the transaction
    i2csr_pkg::i2csr_state_t state_reg, state_next;
    // Phase that follows the acknowledge slot
    i2csr_pkg::i2csr_state_t after_reg, after_next;
    logic [7:0] shift_reg, shift_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] ptr_reg, ptr_next;
    logic [7:0] wdata_reg, wdata_next;
    logic we_reg, we_next;
    // Open-drain pull: one means the line is held low
    logic pull_reg, pull_next;
    logic busy_reg, busy_next;

    // Both lines pass two flops before use
    i2csr_sync u_sync_scl (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .d_i(scl_i),
        .q_o(scl_s)
    );
    i2csr_sync u_sync_sda (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .d_i(sda_i),
        .q_o(sda_s)
    );
    // Address straps are pins too, so they cross through two flops
    logic [2:0] addr_sel_s;
    for (genvar g = 0; g < 3; g++) begin : g_sel_sync
        i2csr_sync u_sync_sel (
            .clock_i(clock_i),
            .rst_n_i(rst_n_i),
            .d_i(addr_sel_i[g]),
            .q_o(addr_sel_s[g])
        );
    end

    // Own address match; fixed high nibble
    function automatic logic addr_hit(input logic [6:0] a, input logic [2:0] sel);
        addr_hit = (a == {i2csr_pkg::ADDR_HI, sel});
    endfunction : addr_hit

    // Edge and condition decode
    always_comb begin
        scl_rise = scl_s && !scl_d_reg;
        scl_fall = !scl_s && scl_d_reg;
        start_cond = scl_s && scl_d_reg && sda_d_reg && !sda_s;
        stop_cond = scl_s && scl_d_reg && !sda_d_reg && sda_s;
    end

    // Next-state logic; any bus rate well below the system clock works, bit timing follows clock edges
    always_comb begin
        state_next = state_reg;
        after_next = after_reg;
        shift_next = shift_reg;
        cnt_next = cnt_reg;
        ptr_next = ptr_reg;
        wdata_next = wdata_reg;
        we_next = 1'b0;
        pull_next = pull_reg;
        busy_next = busy_reg;
        if (stop_cond) begin
            state_next = i2csr_pkg::I2CSR_IDLE;
            pull_next = 1'b0;
            busy_next = 1'b0;
        end else if (start_cond) begin
            state_next = i2csr_pkg::I2CSR_ADDR;
            cnt_next = i2csr_pkg::CNT_RESET;
            pull_next = 1'b0;
            busy_next = 1'b1;
        end else begin
            case (state_reg)
                i2csr_pkg::I2CSR_IDLE: begin
                    pull_next = 1'b0;
                end
                i2csr_pkg::I2CSR_ADDR, i2csr_pkg::I2CSR_PTR, i2csr_pkg::I2CSR_WDATA: begin
                    // sample MSB first on rising clock
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], sda_s};
                        cnt_next = cnt_reg + 4'h1;
                    end
                    if (scl_fall && cnt_reg == i2csr_pkg::BYTE_BITS) begin
                        cnt_next = i2csr_pkg::CNT_RESET;
                        if (state_reg == i2csr_pkg::I2CSR_ADDR) begin
                            if (addr_hit(shift_reg[7:1], addr_sel_s)) begin
                                pull_next = 1'b1;
                                state_next = i2csr_pkg::I2CSR_ACK;
                                after_next = shift_reg[0] ? i2csr_pkg::I2CSR_RDATA
                                                          : i2csr_pkg::I2CSR_PTR;
                            end else begin
                                state_next = i2csr_pkg::I2CSR_IDLE;
                                busy_next = 1'b0;
                            end
                        end else if (state_reg == i2csr_pkg::I2CSR_PTR) begin
                            ptr_next = shift_reg;
                            pull_next = 1'b1;
                            state_next = i2csr_pkg::I2CSR_ACK;
                            after_next = i2csr_pkg::I2CSR_WDATA;
                        end else begin
                            wdata_next = shift_reg;
                            we_next = 1'b1;
                            pull_next = 1'b1;
                            state_next = i2csr_pkg::I2CSR_ACK;
                            after_next = i2csr_pkg::I2CSR_WDATA;
                        end
                    end
                end
                i2csr_pkg::I2CSR_ACK: begin
                    // Release, or drive the first read bit, after the acknowledge clock pulse
                    if (scl_fall) begin
                        state_next = after_reg;
                        cnt_next = i2csr_pkg::CNT_RESET;
                        if (after_reg == i2csr_pkg::I2CSR_RDATA) begin
                            shift_next = reg_rdata_i;
                            pull_next = !reg_rdata_i[7];
                        end else begin
                            pull_next = 1'b0;
                        end
                    end
                end
                i2csr_pkg::I2CSR_RDATA: begin
                    if (scl_rise) begin
                        cnt_next = cnt_reg + 4'h1;
                    end
                    // change data line only while clock low
                    if (scl_fall) begin
                        if (cnt_reg == i2csr_pkg::BYTE_BITS) begin
                            // Release for master acknowledge
                            pull_next = 1'b0;
                            state_next = i2csr_pkg::I2CSR_RACK;
                        end else begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            pull_next = !shift_reg[6];
                        end
                    end
                end
                i2csr_pkg::I2CSR_RACK: begin
                    // master acknowledge; wait for stop or restart
                    pull_next = 1'b0;
                end
                default: begin
                    state_next = i2csr_pkg::I2CSR_IDLE;
                    pull_next = 1'b0;
                end
            endcase
        end
    end

    // Register everything
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            state_reg <= i2csr_pkg::I2CSR_IDLE;
            after_reg <= i2csr_pkg::I2CSR_IDLE;
            shift_reg <= i2csr_pkg::SHIFT_RESET;
            cnt_reg <= i2csr_pkg::CNT_RESET;
            ptr_reg <= i2csr_pkg::PTR_RESET;
            wdata_reg <= i2csr_pkg::SHIFT_RESET;
            we_reg <= 1'b0;
            pull_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
            state_reg <= state_next;
            after_reg <= after_next;
            shift_reg <= shift_next;
            cnt_reg <= cnt_next;
            ptr_reg <= ptr_next;
            wdata_reg <= wdata_next;
            we_reg <= we_next;
            pull_reg <= pull_next;
            busy_reg <= busy_next;
        end
    end

    // no clock output; data pin is open drain only
    assign sda_o = 1'b0;
    assign sda_oe_n_o = !pull_reg;
    assign reg_addr_o = ptr_reg;
    assign reg_wdata_o = wdata_reg;
    assign reg_we_o = we_reg;
    assign pointer_o = ptr_reg;
    assign busy_o = busy_reg;

    AST_NO_PULL_IDLE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state_reg == i2csr_pkg::I2CSR_IDLE) |=> !pull_reg)
        else $error("Data line pulled while idle");
    AST_ACK_PULL: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state_reg == i2csr_pkg::I2CSR_ACK) |-> pull_reg)
        else $error("Acknowledge slot not pulled low");
    AST_WE_PULSE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        reg_we_o |=> !reg_we_o)
        else $error("Write strobe longer than one cycle");
    AST_STOP_IDLE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        stop_cond |=> (state_reg == i2csr_pkg::I2CSR_IDLE && !pull_reg))
        else $error("Stop did not end transfer");
    AST_START_ADDR: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (start_cond && !stop_cond) |=> (state_reg == i2csr_pkg::I2CSR_ADDR))
        else $error("Start not detected");
    // pointer changes only at pointer byte end
    AST_PTR_HOLD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state_reg != i2csr_pkg::I2CSR_PTR) |=> $stable(ptr_reg))
        else $error("Pointer changed outside pointer phase");
    // output changes only when clock low
    AST_SDA_CHANGE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ($changed(pull_reg) && !$past(stop_cond) && !$past(start_cond)) |-> !scl_d_reg)
        else $error("Data line changed while clock high");
    // first read bit equals register MSB
    AST_READ_MSB: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state_reg == i2csr_pkg::I2CSR_ACK && after_reg == i2csr_pkg::I2CSR_RDATA
         && scl_fall && !start_cond && !stop_cond)
        |=> (pull_reg == !$past(reg_rdata_i[7])))
        else $error("Read MSB wrong");
    // open drain, pulls only in own slots
    AST_OPEN_DRAIN: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !sda_oe_n_o |-> (!sda_o && (state_reg == i2csr_pkg::I2CSR_ACK
         || state_reg == i2csr_pkg::I2CSR_RDATA)))
        else $error("Data line pulled outside own slot");
endmodule : i2csr_slave
`default_nettype wire

// ===== shared/i2csr_pkg.sv
`default_nettype none
package i2csr_pkg;
    // Fixed upper four bits of the bus address
    localparam logic [3:0] ADDR_HI = 4'hA;
    // Standard and fast bus rates, in kHz
    localparam int RATE_STD_KHZ = 100;
    localparam int RATE_FAST_KHZ = 400;
    // Bits in one byte
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // Register pointer value after reset
    localparam logic [7:0] PTR_RESET = 8'h00;
    // Receive shifter value after reset
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    // Bit counter value after reset
    localparam logic [3:0] CNT_RESET = 4'h0;
    // Transaction phases
    typedef enum logic [2:0] {
        I2CSR_IDLE,
        I2CSR_ADDR,
        I2CSR_PTR,
        I2CSR_WDATA,
        I2CSR_RDATA,
        I2CSR_ACK,
        I2CSR_RACK
    } i2csr_state_t;
endpackage : i2csr_pkg
`default_nettype wire

// ===== rtl/i2csr_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for one bus line
module i2csr_sync (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic d_i,
    output logic q_o
);
    // Metastable first stage, read only by the second
    logic meta_reg;
    logic meta_next;
    logic q_reg;
    logic q_next;

    // Next values
    always_comb begin
        meta_next = d_i;
        q_next = meta_reg;
    end

    // Lines idle high, so reset to one
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            meta_reg <= 1'b1;
            q_reg <= 1'b1;
        end else begin
            meta_reg <= meta_next;
            q_reg <= q_next;
        end
    end

    assign q_o = q_reg;
endmodule : i2csr_sync
`default_nettype wire

// ===== test/i2csr_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural bus master: owns the clock line, drives data open-drain style
module i2csr_master_model #(
    parameter int HALF = 10 // System cycles per half bus period
) (
    input wire logic clock_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    // Both lines released while idle
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // Waits a number of falling system edges, where all changes land
    task automatic pause(input int n);
        repeat (n) @(negedge clock_i);
    endtask : pause
    // data raised while clock low, then falls with clock high
    task automatic start_cond();
        pause(HALF / 2);
        sda_o = 1'b1;
        pause(HALF - HALF / 2);
        scl_o = 1'b1;
        pause(HALF);
        sda_o = 1'b0;
        pause(HALF);
        scl_o = 1'b0;
    endtask : start_cond
    // stop: data rises with clock high, bus left released
    task automatic stop_cond();
        pause(HALF / 2);
        sda_o = 1'b0;
        pause(HALF - HALF / 2);
        scl_o = 1'b1;
        pause(HALF);
        sda_o = 1'b1;
        pause(HALF);
    endtask : stop_cond
    // one bit; data moves mid low phase, sampled before clock falls
    task automatic bit_xfer(input logic b, output logic seen);
        pause(HALF / 2);
        sda_o = b;
        pause(HALF - HALF / 2);
        scl_o = 1'b1;
        pause(HALF);
        seen = sda_i;
        scl_o = 1'b0;
    endtask : bit_xfer
    // byte out MSB first, then the acknowledge slot
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_xfer(d[i], s);
        bit_xfer(1'b1, s);
        ack = ~s;
    endtask : send_byte
    // byte in MSB first, then our acknowledge or refusal
    task automatic recv_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
        bit_xfer(nack, s);
    endtask : recv_byte
endmodule : i2csr_master_model
`default_nettype wire

// ===== test/i2c_slave_register_access_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the serial register port
module i2c_slave_register_access_tb_top;
    logic clk;
    logic rst_n = 1'b0;
    logic [2:0] addr_sel = 3'b011;
    logic scl, mst_sda, sda_line, sda_o, sda_oe_n, reg_we, busy, ack, oe_low;
    logic [7:0] reg_addr, reg_wdata, pointer, rdata, rd, we_addr, we_data;
    logic [7:0] regs [256];
    int err_total = 0;
    int samples_checked = 0;
    int we_cnt = 0;
    int cycles = 0;
    // Wired-and data line with pull-up
    assign sda_line = mst_sda & (sda_oe_n | sda_o);
    assign rdata = regs[reg_addr];
    // 125 MHz system clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    i2csr_slave u_dut (.clock_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda_line),
        .addr_sel_i(addr_sel), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .reg_addr_o(reg_addr),
        .reg_wdata_o(reg_wdata), .reg_we_o(reg_we), .reg_rdata_i(rdata), .pointer_o(pointer),
        .busy_o(busy));
    // Link clock of 160 ns: ten system cycles per half period
    i2csr_master_model #(.HALF(10)) u_master (.clock_i(clk), .sda_i(sda_line), .scl_o(scl),
        .sda_o(mst_sda));
    // Register file behind the port, plus write and drive monitors
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (sda_oe_n === 1'b0) oe_low <= 1'b1;
        if (reg_we === 1'b1) begin
            regs[reg_addr] <= reg_wdata;
            we_addr <= reg_addr;
            we_data <= reg_wdata;
            we_cnt <= we_cnt + 1;
        end
        // Hang guard, well above the expected run length
        if (cycles == 60000) begin
            err_total++;
            end_of_test();
        end
    end
    function automatic logic [7:0] init_val(input int a);
        return 8'(a) ^ 8'hA5;
    endfunction : init_val
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Address, pointer and data phases; hit says whether acks are due
    task automatic wr_seq(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d,
        input logic hit);
        u_master.start_cond();
        u_master.send_byte({dev, 1'b0}, ack);
        check({7'h00, ack}, {7'h00, hit});
        u_master.send_byte(p, ack);
        check({7'h00, ack}, {7'h00, hit});
        u_master.send_byte(d, ack);
        check({7'h00, ack}, {7'h00, hit});
    endtask : wr_seq
    // Start or repeated start, read address, one byte acknowledged
    task automatic rd_seq(input logic [6:0] dev, input logic [7:0] exp);
        u_master.start_cond();
        u_master.send_byte({dev, 1'b1}, ack);
        check({7'h00, ack}, 8'h01);
        u_master.recv_byte(1'b0, rd);
        check(rd, exp);
    endtask : rd_seq
    task automatic t_write();
        int n0;
        n0 = we_cnt;
        wr_seq(7'h53, 8'h6D, 8'h92, 1'b1);
        check({7'h00, busy}, 8'h01);
        u_master.stop_cond();
        check({7'h00, busy}, 8'h00);
        check(8'(we_cnt - n0), 8'h01);
        check(we_addr, 8'h6D);
        check(we_data, 8'h92);
        check(pointer, 8'h6D);
        $display("t_write done");
    endtask : t_write
    task automatic t_read();
        u_master.start_cond();
        u_master.send_byte(8'hA6, ack);
        u_master.send_byte(8'h6D, ack);
        check({7'h00, ack}, 8'h01);
        rd_seq(7'h53, 8'h92);
        rd_seq(7'h53, 8'h92);
        u_master.stop_cond();
        rd_seq(7'h53, 8'h92);
        u_master.stop_cond();
        $display("t_read done");
    endtask : t_read
    task automatic t_chain();
        wr_seq(7'h53, 8'h20, 8'h3C, 1'b1);
        // Extra data byte rewrites the same register
        u_master.send_byte(8'h5A, ack);
        check({7'h00, ack}, 8'h01);
        check(we_addr, 8'h20);
        check(we_data, 8'h5A);
        wr_seq(7'h53, 8'h21, 8'hC3, 1'b1);
        rd_seq(7'h53, 8'hC3);
        wr_seq(7'h53, 8'h20, 8'h3C, 1'b1);
        rd_seq(7'h53, 8'h3C);
        u_master.stop_cond();
        $display("t_chain done");
    endtask : t_chain
    task automatic t_pins();
        for (int s = 0; s < 8; s++) begin
            addr_sel = 3'(s);
            wr_seq({4'hA, 3'(s)}, 8'h80 + 8'(s), 8'h10 + 8'(s), 1'b1);
            u_master.stop_cond();
            oe_low = 1'b0;
            wr_seq({4'hA, 3'(s) ^ 3'b001}, 8'h40, 8'hEE, 1'b0);
            check({7'h00, busy}, 8'h00);
            u_master.stop_cond();
            wr_seq({4'h2, 3'(s)}, 8'h41, 8'hEF, 1'b0);
            u_master.stop_cond();
            check({7'h00, oe_low}, 8'h00);
            check(pointer, 8'h80 + 8'(s));
            check(we_data, 8'h10 + 8'(s));
        end
        addr_sel = 3'b011;
        $display("t_pins done");
    endtask : t_pins
    task automatic t_reset();
        rst_n = 1'b0;
        u_master.pause(3);
        check(pointer, 8'h00);
        rst_n = 1'b1;
        u_master.pause(3);
        rd_seq(7'h53, init_val(0));
        u_master.stop_cond();
        $display("t_reset done");
    endtask : t_reset
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    // Main sequence: reset held three cycles, then every scenario
    initial begin
        for (int i = 0; i < 256; i++) regs[i] = init_val(i);
        oe_low = 1'b0;
        u_master.pause(3);
        rst_n = 1'b1;
        u_master.pause(3);
        t_write();
        t_read();
        t_chain();
        t_pins();
        t_reset();
        end_of_test();
    end
endmodule : i2c_slave_register_access_tb_top
`default_nettype wire
